// file: hw/boot_startup_sequencer.sv
/*
 Boot startup sequencer: reset classification, boot-mode capture, ordered init
 steps and final loader or user entry. Assumes the self-test, clear, map and trim
 steps are each done by an outside engine with a start level held through the step and a done level, and that NVM words are
 presented as stable inputs once the sequencer asks for them.
*/
`timescale 1ns/1ps
`default_nettype none
module boot_startup_sequencer #(
   parameter int unsigned NAC_STEP_CYC = boot_seq_pkg::NAC_STEP_CYC,
   parameter int unsigned PLL_LOCK_CYC = boot_seq_pkg::PLL_LOCK_CYC
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ext_reset_pin_in,
   input wire logic boot_select_pin_a_in,
   input wire logic boot_select_pin_b_in,
   input wire logic [1:0] reset_type_in,
   input wire logic bist_forced_in,
   input wire logic nvm_protected_in,
   input wire logic [7:0] no_activity_count_in,
   input wire logic nac_read_error_in,
   input wire logic [31:0] reset_vector_in,
   input wire logic step_done_in,
   input wire logic pll_locked_in,
   input wire logic loader_activity_in,
   input wire logic debugger_sync_in,
   output logic [13:0] state_out,
   output logic step_start_out,
   output logic first_watchdog_off_out,
   output logic clk_from_pll_out,
   output logic clk_fallback_out,
   output logic debug_mode_out,
   output logic loader_active_out,
   output logic user_entry_out,
   output logic sleep_out,
   output logic [31:0] vector_table_base_out,
   output logic [31:0] branch_addr_out,
   output logic [31:0] fetch_base_out,
   output logic [31:0] scratch_lo_out,
   output logic [31:0] scratch_hi_out
);
   boot_seq_pkg::seq_state_e state_reg, state_next;
   logic pin_prev_reg;
   logic [1:0] mode_pins_reg;
   logic [1:0] rst_type_reg;
   logic [31:0] timer_reg, timer_next;
   logic [7:0] nac_left_reg, nac_left_next;
   logic wdog_off_reg, wdog_off_next;
   logic pll_reg, pll_next;
   logic fallback_reg, fallback_next;
   logic [31:0] vector_table_base_reg, vector_table_base_next;
   logic [31:0] branch_reg, branch_next;

   wire pin_rise = ext_reset_pin_in & ~pin_prev_reg;
   // Pin a high with pin b high selects debug; pin b is a don't-care when pin a is low.
   wire debug_mode = mode_pins_reg[1] & mode_pins_reg[0];
   wire cold_rst = (rst_type_reg == boot_seq_pkg::RST_COLD);
   wire hot_rst = (rst_type_reg == boot_seq_pkg::RST_HOT);
   wire run_bist = cold_rst | bist_forced_in;
   wire run_trim = ~hot_rst;
   wire vec_erased = (reset_vector_in == boot_seq_pkg::ERASED_WORD);
   wire nac_bad = nac_read_error_in | ((no_activity_count_in > boot_seq_pkg::NAC_MAX_COUNT)
      & (no_activity_count_in != boot_seq_pkg::NAC_FOREVER));
   wire nac_forever = nac_bad | (no_activity_count_in == boot_seq_pkg::NAC_FOREVER);
   wire step_tick = (timer_reg == NAC_STEP_CYC - 1);
   wire pll_timeout = (timer_reg >= PLL_LOCK_CYC - 1);
   wire in_step = (state_reg == boot_seq_pkg::ST_BIST) | (state_reg == boot_seq_pkg::ST_CLEAR)
      | (state_reg == boot_seq_pkg::ST_MAP) | (state_reg == boot_seq_pkg::ST_TRIM);

   // Boot-mode pins are sampled on the pin's rising edge, not under reset, so the async
   // reset only loads constants.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pin_prev_reg <= 1'b0;
         mode_pins_reg <= 2'h0;
      end else begin
         pin_prev_reg <= ext_reset_pin_in;
         if (pin_rise) begin
            mode_pins_reg <= {boot_select_pin_a_in, boot_select_pin_b_in};
         end
      end
   end

   // Sequencer state and its working registers.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= boot_seq_pkg::ST_CLASSIFY;
         rst_type_reg <= boot_seq_pkg::RST_COLD;
         timer_reg <= 32'h0;
         nac_left_reg <= 8'h0;
         wdog_off_reg <= 1'b0;
         pll_reg <= 1'b0;
         fallback_reg <= 1'b0;
         vector_table_base_reg <= boot_seq_pkg::ROM_BASE;
         branch_reg <= boot_seq_pkg::ROM_BASE;
      end else begin
         state_reg <= state_next;
         if (state_reg == boot_seq_pkg::ST_CLASSIFY) begin
            rst_type_reg <= reset_type_in;
         end
         timer_reg <= timer_next;
         nac_left_reg <= nac_left_next;
         wdog_off_reg <= wdog_off_next;
         pll_reg <= pll_next;
         fallback_reg <= fallback_next;
         vector_table_base_reg <= vector_table_base_next;
         branch_reg <= branch_next;
      end
   end

   // Step order is fixed; a skipped self-test falls through to the clear step, and a skipped trim also skips the PLL step.
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      nac_left_next = nac_left_reg;
      wdog_off_next = wdog_off_reg;
      pll_next = pll_reg;
      fallback_next = fallback_reg;
      vector_table_base_next = vector_table_base_reg;
      branch_next = branch_reg;
      unique case (state_reg)
         boot_seq_pkg::ST_CLASSIFY: begin
            state_next = boot_seq_pkg::ST_WDOG;
         end
         boot_seq_pkg::ST_WDOG: begin
            wdog_off_next = debug_mode;
            state_next = run_bist ? boot_seq_pkg::ST_BIST : boot_seq_pkg::ST_CLEAR;
         end
         boot_seq_pkg::ST_BIST: begin
            if (step_done_in) state_next = boot_seq_pkg::ST_CLEAR;
         end
         boot_seq_pkg::ST_CLEAR: begin
            if (step_done_in) state_next = boot_seq_pkg::ST_MAP;
         end
         boot_seq_pkg::ST_MAP: begin
            if (step_done_in) begin
               state_next = run_trim ? boot_seq_pkg::ST_TRIM : boot_seq_pkg::ST_NAC_START;
            end
         end
         boot_seq_pkg::ST_TRIM: begin
            if (step_done_in) begin
               timer_next = 32'h0;
               state_next = boot_seq_pkg::ST_PLL;
            end
         end
         boot_seq_pkg::ST_PLL: begin
            timer_next = timer_reg + 32'h1;
            if (pll_locked_in) begin
               pll_next = 1'b1;
               state_next = boot_seq_pkg::ST_NAC_START;
            end else if (pll_timeout) begin
               fallback_next = 1'b1;
               state_next = boot_seq_pkg::ST_NAC_START;
            end
         end
         boot_seq_pkg::ST_NAC_START: begin
            timer_next = 32'h0;
            nac_left_next = no_activity_count_in;
            if (debug_mode) begin
               state_next = debugger_sync_in ? boot_seq_pkg::ST_VECTOR : state_reg;
            end else if (nac_forever) begin
               wdog_off_next = 1'b1;
               state_next = boot_seq_pkg::ST_LOADER;
            end else if (no_activity_count_in == boot_seq_pkg::NAC_CLOSED) begin
               state_next = boot_seq_pkg::ST_VECTOR;
            end else begin
               state_next = boot_seq_pkg::ST_WINDOW;
            end
         end
         boot_seq_pkg::ST_WINDOW: begin
            timer_next = step_tick ? 32'h0 : timer_reg + 32'h1;
            if (step_tick) nac_left_next = nac_left_reg - 8'h1;
            if (loader_activity_in) begin
               state_next = boot_seq_pkg::ST_LOADER;
            end else if (step_tick && nac_left_reg == 8'h1) begin
               state_next = boot_seq_pkg::ST_VECTOR;
            end
         end
         boot_seq_pkg::ST_LOADER: begin
            state_next = state_reg; // Loader protocol runs outside this block.
         end
         boot_seq_pkg::ST_VECTOR: begin
            if (!vec_erased) begin
               vector_table_base_next = boot_seq_pkg::NVM_BASE;
               branch_next = reset_vector_in;
               state_next = boot_seq_pkg::ST_USER;
            end else if (!nvm_protected_in) begin
               state_next = boot_seq_pkg::ST_SLEEP;
            end else begin
               state_next = boot_seq_pkg::ST_HALT;
            end
         end
         boot_seq_pkg::ST_USER, boot_seq_pkg::ST_SLEEP, boot_seq_pkg::ST_HALT: begin
            state_next = state_reg;
         end
         default: begin
            state_next = boot_seq_pkg::ST_CLASSIFY;
         end
      endcase
   end

   // Outputs. The vector fetch address is a constant, driven in every state.
   assign state_out = state_reg;
   assign step_start_out = in_step;
   assign first_watchdog_off_out = wdog_off_reg;
   assign clk_from_pll_out = pll_reg;
   assign clk_fallback_out = fallback_reg;
   assign debug_mode_out = debug_mode;
   assign loader_active_out = (state_reg == boot_seq_pkg::ST_LOADER) | (state_reg == boot_seq_pkg::ST_WINDOW);
   assign user_entry_out = (state_reg == boot_seq_pkg::ST_USER);
   assign sleep_out = (state_reg == boot_seq_pkg::ST_SLEEP);
   assign vector_table_base_out = vector_table_base_reg;
   assign branch_addr_out = branch_reg;
   assign fetch_base_out = boot_seq_pkg::RESET_VEC_ADDR;
   // The sequencer's own variables stay inside this window only.
   assign scratch_lo_out = boot_seq_pkg::ROM_RAM_LO;
   assign scratch_hi_out = boot_seq_pkg::ROM_RAM_HI;
endmodule
`default_nettype wire

// file: hw/boot_seq_pkg.sv
/*
 Constants, state codes and timing counts of the boot startup sequencer.
 Assumes a 40 MHz system clock; included before the sequencer module.
*/
// Overview of operation
// - First step after any reset classifies the reset type before anything else.
// - Both boot-mode pins are captured at the external reset rising edge and held.
// - Exactly two modes exist: user/loader mode and debug-support mode.
// - The reset type (and bist_forced_in for self-test) decides which initialization steps run or are skipped.
// - User entry needs a reset vector not all ones and a proper no-activity count.
// - Unprotected memory with erased reset vector sends the device to sleep.
// - Invalid stored no-activity count means waiting forever for a fast loader host.
// - Sequencer uses only its reserved RAM window; other RAM kept without self-test.
// - User entry points vector table at memory start, branches to vector at 11000004.
// - Startup logic sits at address zero, acting as the reset handler.
// - First watchdog is disabled or left running according to the boot mode.
// - RAM self-test is an optional startup step.
// - RAM is always cleared to zero during startup.
// - Mapping RAM is initialized from the stored mapping block data.
// - Analog trim values are copied from the configuration sector into hardware.
// - System clock is switched over to the PLL output.
// - A dedicated no-activity timer is started.
// - After initialization, start loader communication or branch into user code.
// - Count is eight bits, timeout is count times 5 ms, at most 140 ms.
// - Count 00 closes the loader window and enters user mode at once.
// - Count FF disables timeout, switches off watchdog, waits forever for loader.
// - PLL not locked within 1 ms falls back to oscillator divided by four.
package boot_seq_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned NAC_STEP_MS = 5;
   localparam int unsigned NAC_MAX_MS = 140;
   localparam int unsigned PLL_LOCK_MS = 1;
   localparam int unsigned NAC_STEP_CYC = CLK_HZ / 1000 * NAC_STEP_MS;
   localparam int unsigned PLL_LOCK_CYC = CLK_HZ / 1000 * PLL_LOCK_MS;
   localparam logic [7:0] NAC_MAX_COUNT = 8'(NAC_MAX_MS / NAC_STEP_MS);
   localparam logic [7:0] NAC_CLOSED = 8'h00;
   localparam logic [7:0] NAC_FOREVER = 8'hFF;
   localparam logic [31:0] ROM_BASE = 32'h00000000;
   localparam logic [31:0] NVM_BASE = 32'h11000000;
   localparam logic [31:0] RESET_VEC_ADDR = 32'h11000004;
   localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
   localparam logic [31:0] ROM_RAM_LO = 32'h18000000;
   localparam logic [31:0] ROM_RAM_HI = 32'h180003FF;
   // Reset type codes.
   localparam logic [1:0] RST_COLD = 2'h0;
   localparam logic [1:0] RST_WARM = 2'h1;
   localparam logic [1:0] RST_HOT = 2'h2;
   typedef enum logic [13:0] {
      ST_CLASSIFY = 14'h0001,
      ST_WDOG = 14'h0002,
      ST_BIST = 14'h0004,
      ST_CLEAR = 14'h0008,
      ST_MAP = 14'h0010,
      ST_TRIM = 14'h0020,
      ST_PLL = 14'h0040,
      ST_NAC_START = 14'h0080,
      ST_WINDOW = 14'h0100,
      ST_LOADER = 14'h0200,
      ST_VECTOR = 14'h0400,
      ST_USER = 14'h0800,
      ST_SLEEP = 14'h1000,
      ST_HALT = 14'h2000
   } seq_state_e;
endpackage

// file: sim/seq_asserts.sv
/* Port checker of the boot startup sequencer.
   Assumes the sequencer's single clock and its asynchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module seq_asserts (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic step_done_in,
   input wire logic pll_locked_in,
   input wire logic nvm_protected_in,
   input wire logic nac_read_error_in,
   input wire logic [7:0] no_activity_count_in,
   input wire logic [31:0] reset_vector_in,
   input wire logic [13:0] state_out,
   input wire logic first_watchdog_off_out,
   input wire logic clk_from_pll_out,
   input wire logic debug_mode_out,
   input wire logic user_entry_out,
   input wire logic sleep_out,
   input wire logic [31:0] vector_table_base_out,
   input wire logic [31:0] branch_addr_out
);
   // Reset holds the first state, so every check is off while it is asserted.
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   classify_first_a: assert property (state_out == boot_seq_pkg::ST_CLASSIFY |=>
      state_out == boot_seq_pkg::ST_WDOG) else $error("classify not followed by watchdog step");
   clear_step_a: assert property (state_out == boot_seq_pkg::ST_CLEAR |=>
      state_out == ($past(step_done_in) ? boot_seq_pkg::ST_MAP : boot_seq_pkg::ST_CLEAR)) else $error("clear step");
   map_done_a: assert property (state_out == boot_seq_pkg::ST_MAP && step_done_in |=>
      state_out inside {boot_seq_pkg::ST_TRIM, boot_seq_pkg::ST_NAC_START}) else $error("map step");
   pll_switch_a: assert property (state_out == boot_seq_pkg::ST_PLL && pll_locked_in |=>
      state_out == boot_seq_pkg::ST_NAC_START && clk_from_pll_out) else $error("pll switch");
   nac_closed_a: assert property (state_out == boot_seq_pkg::ST_NAC_START && !debug_mode_out &&
      !nac_read_error_in && no_activity_count_in == 8'h00 |=> state_out == boot_seq_pkg::ST_VECTOR)
      else $error("count zero");
   nac_forever_a: assert property (state_out == boot_seq_pkg::ST_NAC_START && !debug_mode_out &&
      no_activity_count_in == 8'hFF |=> state_out == boot_seq_pkg::ST_LOADER ##[0:1] first_watchdog_off_out)
      else $error("count all ones");
   user_entry_a: assert property ($rose(user_entry_out) |-> branch_addr_out == $past(reset_vector_in) &&
      branch_addr_out != 32'hFFFFFFFF && vector_table_base_out == 32'h11000000) else $error("user entry");
   sleep_entry_a: assert property ($rose(sleep_out) |->
      $past(reset_vector_in) == 32'hFFFFFFFF && !$past(nvm_protected_in)) else $error("sleep entry");
endmodule
bind boot_startup_sequencer seq_asserts seq_asserts_inst (.clk_sys_in, .rst_in, .step_done_in, .pll_locked_in,
   .nvm_protected_in, .nac_read_error_in, .no_activity_count_in, .reset_vector_in, .state_out,
   .first_watchdog_off_out,
   .clk_from_pll_out, .debug_mode_out, .user_entry_out, .sleep_out, .vector_table_base_out, .branch_addr_out);
`default_nettype wire

// file: sim/boot_host_model.sv
/* Far-side model: step engine, boot host and debugger.
   Assumes the sequencer's clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module boot_host_model (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic step_start_in,
   input wire logic [3:0] delay_in,
   input wire logic debug_in,
   input wire logic send_in,
   output logic step_done_out,
   output logic activity_out,
   output logic sync_out
);
   logic [3:0] wait_reg;
   // A step ends after delay_in cycles, so prompt and slow engines both occur.
   assign step_done_out = step_start_in && (wait_reg == delay_in);
   assign activity_out = send_in;
   // The debugger syncs one cycle after debug mode shows.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wait_reg <= 4'h0;
         sync_out <= 1'b0;
      end else begin
         wait_reg <= (step_start_in && !step_done_out) ? wait_reg + 4'h1 : 4'h0;
         sync_out <= debug_in;
      end
   end
endmodule
`default_nettype wire

// file: sim/boot_startup_sequencer_test.sv
/* Self-checking bench of the boot startup sequencer.
   Assumes both long counts shortened to 4 cycles. */
`timescale 1ns/1ps
`default_nettype none
module boot_startup_sequencer_test;
   localparam int unsigned STEP = 4;
   logic clk = 1'b0, rst = 1'b1, ext = 1'b0, pa = 1'b0, pb = 1'b0, bf = 1'b0, prot = 1'b0, err = 1'b0;
   logic lock = 1'b1, send = 1'b0, start, done, wd, pll, fb, dbg, usr, slp, act, syn, la;
   logic [1:0] rt = 2'h0;
   logic [3:0] dly = 4'h0;
   logic [7:0] no_activity_count = 8'h00;
   logic [13:0] st, mask, last;
   logic [31:0] vec = 32'h00001235, vtb, br, fet, slo, shi;
   int errors = 0, n_checks = 0, win;
   boot_startup_sequencer #(.NAC_STEP_CYC(STEP), .PLL_LOCK_CYC(STEP)) boot_startup_sequencer_inst (
      .clk_sys_in(clk), .rst_in(rst), .ext_reset_pin_in(ext), .boot_select_pin_a_in(pa),
      .boot_select_pin_b_in(pb), .reset_type_in(rt), .bist_forced_in(bf), .nvm_protected_in(prot),
      .no_activity_count_in(no_activity_count), .nac_read_error_in(err), .reset_vector_in(vec), .step_done_in(done),
      .pll_locked_in(lock), .loader_activity_in(act), .debugger_sync_in(syn), .state_out(st),
      .step_start_out(start), .first_watchdog_off_out(wd), .clk_from_pll_out(pll), .clk_fallback_out(fb),
      .debug_mode_out(dbg), .loader_active_out(la), .user_entry_out(usr), .sleep_out(slp),
      .vector_table_base_out(vtb), .branch_addr_out(br), .fetch_base_out(fet), .scratch_lo_out(slo),
      .scratch_hi_out(shi));
   boot_host_model boot_host_model_inst (.clk_sys_in(clk), .rst_in(rst), .step_start_in(start),
      .delay_in(dly), .debug_in(dbg), .send_in(send), .step_done_out(done), .activity_out(act), .sync_out(syn));
   // 40 MHz clock.
   always #12.5 clk = ~clk;
   // One-hot codes rise along the fixed order, so a drop means a step out of order.
   always @(posedge clk) begin
      if (!rst && st < last) begin
         errors++;
         $display("Error state order expected above %h seen %h", last, st);
      end
      mask = mask | st;
      last = st;
      if (st == boot_seq_pkg::ST_WINDOW) win++;
   end
   task automatic report_and_stop();
      $display("Checks made %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Reset for 3 cycles; the pin edge at release latches the mode pins.
   task automatic boot(input logic [1:0] t, input logic [7:0] n, input logic [31:0] v, input logic a);
      @(posedge clk);
      rst <= 1'b1;
      ext <= 1'b0;
      rt <= t;
      no_activity_count <= n;
      vec <= v;
      pa <= a;
      pb <= a;
      repeat (3) @(posedge clk);
      mask = '0;
      last = '0;
      win = 0;
      rst <= 1'b0;
      ext <= 1'b1;
   endtask
   task automatic wait_for(input logic [13:0] m);
      int i;
      for (i = 0; i < 400 && (st & m) == '0; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 400) begin
         errors++;
         $display("Error wait expected %h seen %h", m, st);
         report_and_stop();
      end
      // Return on a rising edge so that the caller's next drive lands on the edge.
      @(posedge clk);
   endtask
   task automatic cold_user();
      dly <= 4'h3;
      boot(2'h0, 8'h02, 32'h00001235, 1'b0);
      wait_for(14'h3A00);
      chk("states", 32'h0DFF, mask | st);
      chk("window", 2 * STEP, win);
      chk("vector table", 32'h11000000, vtb);
      chk("branch", 32'h00001235, br);
      chk("user entry", 1'b1, usr);
      chk("fetch", 32'h11000004, fet);
      chk("scratch lo", 32'h18000000, slo);
      chk("scratch hi", 32'h180003FF, shi);
      chk("flags", 3'b001, {dbg, wd, pll});
      dly <= 4'h0;
      $display("cold_user done");
   endtask
   task automatic hot_closed();
      boot(2'h2, 8'h00, 32'h00001235, 1'b0);
      wait_for(14'h3A00);
      chk("states", 32'h0C9B, mask | st);
      chk("pll", 1'b0, pll);
      $display("hot_closed done");
   endtask
   task automatic erased_vector();
      for (int p = 0; p < 2; p++) begin
         lock <= 1'b0;
         bf <= 1'b1;
         prot <= p[0];
         boot(2'h1, 8'h00, 32'hFFFFFFFF, 1'b0);
         wait_for(14'h3A00);
         chk("states", p ? 32'h24FF : 32'h14FF, mask | st);
         chk("fallback", 2'b01, {pll, fb});
      end
      lock <= 1'b1;
      bf <= 1'b0;
      prot <= 1'b0;
      $display("erased_vector done");
   endtask
   task automatic bad_count();
      for (int k = 0; k < 3; k++) begin
         err <= (k == 2);
         boot(2'h0, k == 0 ? 8'hFF : k == 1 ? 8'h1D : 8'h05, 32'h00001235, 1'b0);
         wait_for(14'h3A00);
         chk("states", 32'h02FF, mask | st);
         chk("watchdog", 1'b1, wd);
         chk("loader active", 1'b1, la);
      end
      err <= 1'b0;
      $display("bad_count done");
   endtask
   task automatic window_cases();
      boot(2'h0, 8'h1C, 32'h00001235, 1'b0);
      wait_for(14'h3A00);
      chk("longest window", 28 * STEP, win);
      boot(2'h0, 8'h03, 32'h00001235, 1'b0);
      wait_for(boot_seq_pkg::ST_WINDOW);
      chk("window active", 1'b1, la);
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      wait_for(14'h3A00);
      chk("states", 32'h03FF, mask | st);
      $display("window_cases done");
   endtask
   task automatic debug_entry();
      boot(2'h0, 8'hFF, 32'h00001235, 1'b1);
      @(posedge clk);
      pa <= 1'b0;
      wait_for(14'h3A00);
      chk("states", 32'h0CFF, mask | st);
      chk("debug", 2'b11, {dbg, wd});
      $display("debug_entry done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      cold_user();
      hot_closed();
      erased_vector();
      bad_count();
      window_cases();
      debug_entry();
      report_and_stop();
   end
endmodule
`default_nettype wire
